// >>> acsf_ahb_slave.sv
// AHB-Lite slave: zero-wait single word access into the register core
`timescale 1ns/1ps
`default_nettype none
module acsf_ahb_slave
    import acsf_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    output logic [31:0] hrdata_o,
    acsf_reg_if.slave rif
);
    logic ph_wr_r;
    logic ph_rd_r;
    logic [7:0] ph_addr_r;
    wire take = hsel_i && hready_i && htrans_i[1];
    // Capture the address phase; data phase follows next cycle
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ph_wr_r <= 1'b0;
            ph_rd_r <= 1'b0;
            ph_addr_r <= 8'h00;
        end else begin
            ph_wr_r <= take && hwrite_i;
            ph_rd_r <= take && !hwrite_i;
            ph_addr_r <= take ? haddr_i[7:0] : ph_addr_r;
        end
    end
    // Write commits in the data phase; read data sampled combinationally
    assign rif.wr = ph_wr_r;
    assign rif.rd = ph_rd_r;
    assign rif.addr = ph_addr_r;
    assign rif.wdata = hwdata_i;
    assign hrdata_o = rif.rdata;
endmodule
`default_nettype wire

// >>> acsf_cmp_model.sv
// Partner model: comparator outputs and external capture pin seen by the block
`timescale 1ns/1ps
`default_nettype none
module acsf_cmp_model (
    input wire logic mclk_i,
    output logic cmp_a_o,
    output logic cmp_b_o,
    output logic capture_pin_o
);
    // Comparators start low, as they are powered down out of reset
    initial begin
        cmp_a_o = 1'b0;
        cmp_b_o = 1'b0;
        capture_pin_o = 1'b0;
    end

    // Levels change just after a clock edge; the block resynchronises them anyway
    task automatic drive(input bit sel_b, input logic val);
        @(posedge mclk_i);
        if (sel_b) begin
            cmp_b_o <= val;
        end else begin
            cmp_a_o <= val;
        end
    endtask

    // External capture pin level
    task automatic cap(input logic val);
        @(posedge mclk_i);
        capture_pin_o <= val;
    endtask
endmodule
`default_nettype wire

// >>> acsf_pkg.sv
// Package: register map, field positions and reset values for the analog status block
package acsf_pkg;
    // Register byte addresses
    localparam logic [7:0] ACSF_STATUS_OFS = 8'h00;
    localparam logic [7:0] ACSF_CONTROL_OFS = 8'h04;
    localparam logic [7:0] ACSF_IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] ACSF_IRQ_MASK_OFS = 8'h0C;
    localparam logic [7:0] ACSF_CONFIG_OFS = 8'h10;
    // Status register fields
    localparam int ACSF_B_FLAG_BIT = 7;
    localparam int ACSF_A_FLAG_BIT = 6;
    localparam int ACSF_B_CLR_BIT = 5;
    localparam int ACSF_A_CLR_BIT = 4;
    localparam int ACSF_OFFSET_BIT = 3;
    localparam int ACSF_PIN_OE_BIT = 2;
    localparam int ACSF_B_LIVE_BIT = 1;
    localparam int ACSF_A_LIVE_BIT = 0;
    // Control register fields
    localparam int ACSF_CHG_MSB = 7;
    localparam int ACSF_CHG_LSB = 5;
    localparam int ACSF_SRC_EN_BIT = 4;
    localparam int ACSF_HOLD_BIT = 3;
    localparam int ACSF_DIFF_HOLD_BIT = 2;
    localparam int ACSF_CAPR_BIT = 1;
    localparam int ACSF_IRQEN_BIT = 0;
    // Irq status/mask fields
    localparam int ACSF_IRQ_A_BIT = 0;
    localparam int ACSF_IRQ_B_BIT = 1;
    // Config register fields
    localparam int ACSF_OPTION_BIT = 0;
    localparam int ACSF_DIR_BIT = 1;
    localparam int ACSF_DATA_BIT = 2;
    localparam int ACSF_LEVEL_BIT = 3;
    // Reset values, and the AHB NONSEQ transfer code
    localparam logic [7:0] ACSF_STATUS_RST = 8'h00;
    localparam logic [7:0] ACSF_CONTROL_RST = 8'h00;
    localparam logic [1:0] ACSF_IRQ_RST = 2'h0;
    localparam logic [3:0] ACSF_CONFIG_RST = 4'h0;
    localparam logic [1:0] ACSF_HTRANS_NONSEQ = 2'h2;
endpackage

// >>> acsf_reg_if.sv
// Interface: decoded register access from the bus slave to the register core
`timescale 1ns/1ps
`default_nettype none
interface acsf_reg_if;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport slave (output wr, output rd, output addr, output wdata, input rdata);
    modport core (input wr, input rd, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// >>> acsf_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module acsf_sync (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    // First stage is read only by the second
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            q_o <= 1'b0;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                q_o <= s3_r;
            end
        end
    end
endmodule
`default_nettype wire

// >>> acsf_top.sv
// Analog comparator status and control register bank with AHB-Lite access
`timescale 1ns/1ps
`default_nettype none
module acsf_top
    import acsf_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic [2:0] hsize_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic cmp_a_i,
    input wire logic cmp_b_i,
    input wire logic capture_pin_i,
    output logic irq_o,
    output logic sample_offset_o,
    output logic pin_out_o,
    output logic charge_ctl_en_o,
    output logic [2:0] charge_ctl_o,
    output logic capture_src_o
);
    acsf_reg_if rif ();

    logic cmp_a_s;
    logic cmp_b_s;
    logic capture_pin_s;
    logic cmp_a_d_r;
    logic cmp_b_d_r;
    logic cmp_a_edge_flag_r;
    logic cmp_b_edge_flag_r;
    logic sample_offset_enable_r;
    logic cmp_a_pin_output_enable_r;
    logic [7:0] analog_control_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_mask_r;
    logic [3:0] config_r;
    logic [31:0] rdata_r;

    // Bus slave front end
    acsf_ahb_slave u_bus (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hready_i(hready_i),
        .hwdata_i(hwdata_i),
        .hrdata_o(hrdata_o),
        .rif(rif)
    );

    // Comparator outputs are analog-domain, so synchronise first
    acsf_sync u_sync_a (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .d_i(cmp_a_i),
        .q_o(cmp_a_s)
    );
    acsf_sync u_sync_b (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .d_i(cmp_b_i),
        .q_o(cmp_b_s)
    );

    // External capture pin is asynchronous as well
    acsf_sync u_sync_cap (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .d_i(capture_pin_i),
        .q_o(capture_pin_s)
    );

    // One address compare per register, qualified by the strobe
    function automatic logic reg_hit(input logic strobe, input logic [7:0] a, input logic [7:0] ofs);
        return strobe && (a == ofs);
    endfunction

    // Register write decode
    wire wr_status = reg_hit(rif.wr, rif.addr, ACSF_STATUS_OFS);
    wire wr_control = reg_hit(rif.wr, rif.addr, ACSF_CONTROL_OFS);
    wire wr_irq_stat = reg_hit(rif.wr, rif.addr, ACSF_IRQ_STAT_OFS);
    wire wr_irq_mask = reg_hit(rif.wr, rif.addr, ACSF_IRQ_MASK_OFS);
    wire wr_config = reg_hit(rif.wr, rif.addr, ACSF_CONFIG_OFS);
    wire option_on = config_r[ACSF_OPTION_BIT];

    // Edge detection on synchronised comparator outputs
    wire rise_a = cmp_a_s && !cmp_a_d_r;
    wire rise_b = cmp_b_s && !cmp_b_d_r;
    // A zero in a clear bit is no request at all
    wire clr_a = wr_status && rif.wdata[ACSF_A_CLR_BIT];
    wire clr_b = wr_status && rif.wdata[ACSF_B_CLR_BIT];

    // Set has priority, so an edge during a clear write is kept
    wire flag_a_nxt = rise_a | (cmp_a_edge_flag_r & ~clr_a);
    wire flag_b_nxt = rise_b | (cmp_b_edge_flag_r & ~clr_b);

    // Interrupt status sets on flag events, cleared by writing one
    wire [1:0] irq_ev = {rise_b, rise_a};
    wire [1:0] irq_clr = wr_irq_stat ? rif.wdata[1:0] : 2'h0;
    wire [1:0] irq_stat_nxt = irq_ev | (irq_stat_r & ~irq_clr);

    // Flags and edge history
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cmp_a_d_r <= 1'b0;
            cmp_b_d_r <= 1'b0;
            cmp_a_edge_flag_r <= 1'b0;
            cmp_b_edge_flag_r <= 1'b0;
        end else begin
            cmp_a_d_r <= cmp_a_s;
            cmp_b_d_r <= cmp_b_s;
            cmp_a_edge_flag_r <= flag_a_nxt;
            cmp_b_edge_flag_r <= flag_b_nxt;
        end
    end

    // Status control bits
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sample_offset_enable_r <= 1'b0;
            cmp_a_pin_output_enable_r <= 1'b0;
        end else if (wr_status) begin
            sample_offset_enable_r <= rif.wdata[ACSF_OFFSET_BIT];
            cmp_a_pin_output_enable_r <= rif.wdata[ACSF_PIN_OE_BIT];
        end
    end

    // Control, mask and configuration registers
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            analog_control_r <= ACSF_CONTROL_RST;
            irq_mask_r <= ACSF_IRQ_RST;
            irq_stat_r <= ACSF_IRQ_RST;
            config_r <= ACSF_CONFIG_RST;
        end else begin
            analog_control_r <= wr_control ? rif.wdata[7:0] : analog_control_r;
            irq_mask_r <= wr_irq_mask ? rif.wdata[1:0] : irq_mask_r;
            irq_stat_r <= irq_stat_nxt;
            config_r <= wr_config ? rif.wdata[3:0] : config_r;
        end
    end

    // Effective option-gated offset and pin enables, plus hold, source enable and any-flag terms
    wire offset_eff = sample_offset_enable_r & option_on;
    wire pin_oe_eff = cmp_a_pin_output_enable_r & option_on;
    wire holds_clear = ~analog_control_r[ACSF_HOLD_BIT] & ~analog_control_r[ACSF_DIFF_HOLD_BIT];
    wire src_en = analog_control_r[ACSF_SRC_EN_BIT];
    wire flag_any = cmp_a_edge_flag_r | cmp_b_edge_flag_r;
    // Sticky masked events, or the enable-gated view of the edge flags
    wire irq_nxt = (|(irq_stat_r & irq_mask_r)) | (analog_control_r[ACSF_IRQEN_BIT] & flag_any);

    // Status register read image
    wire [7:0] status_img = {cmp_b_edge_flag_r, cmp_a_edge_flag_r,
        1'b0, 1'b0,
        offset_eff, pin_oe_eff,
        cmp_b_s, cmp_a_s};

    // Read mux
    always_comb begin
        case (rif.addr)
            ACSF_STATUS_OFS: rdata_r = {24'h00_0000, status_img};
            ACSF_CONTROL_OFS: rdata_r = {24'h00_0000, analog_control_r};
            ACSF_IRQ_STAT_OFS: rdata_r = {30'h0000_0000, irq_stat_r};
            ACSF_IRQ_MASK_OFS: rdata_r = {30'h0000_0000, irq_mask_r};
            ACSF_CONFIG_OFS: rdata_r = {28'h000_0000, config_r};
            default: rdata_r = 32'h0000_0000;
        endcase
    end
    assign rif.rdata = rdata_r;

    // Registered outputs
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
            sample_offset_o <= 1'b0;
            pin_out_o <= 1'b0;
            charge_ctl_en_o <= 1'b0;
            charge_ctl_o <= 3'h0;
            capture_src_o <= 1'b0;
        end else begin
            irq_o <= irq_nxt;
            sample_offset_o <= offset_eff & holds_clear;
            // Pin drive ORs data and level in either direction; the comparator term only when the direction is output
            pin_out_o <= config_r[ACSF_DATA_BIT] | config_r[ACSF_LEVEL_BIT]
                | (pin_oe_eff & config_r[ACSF_DIR_BIT] & cmp_a_s);
            charge_ctl_en_o <= src_en;
            charge_ctl_o <= src_en ? analog_control_r[ACSF_CHG_MSB:ACSF_CHG_LSB] : 3'h0;
            capture_src_o <= analog_control_r[ACSF_CAPR_BIT] ? cmp_b_edge_flag_r : capture_pin_s;
        end
    end

    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    // Assertions
    sequence s_rise_b;
        cmp_b_s && !cmp_b_d_r;
    endsequence
    sequence s_rise_a;
        cmp_a_s && !cmp_a_d_r;
    endsequence

    property p_flag_b_set;
        @(posedge mclk_i) disable iff (rst_i) s_rise_b |=> cmp_b_edge_flag_r;
    endproperty
    a_flag_b_set: assert property (p_flag_b_set) else $error("B flag not set on edge");

    property p_flag_a_set;
        @(posedge mclk_i) disable iff (rst_i) s_rise_a |=> cmp_a_edge_flag_r;
    endproperty
    a_flag_a_set: assert property (p_flag_a_set) else $error("A flag not set on edge");

    property p_flag_b_clr;
        @(posedge mclk_i) disable iff (rst_i) (clr_b && !rise_b) |=> !cmp_b_edge_flag_r;
    endproperty
    a_flag_b_clr: assert property (p_flag_b_clr) else $error("B flag not cleared");

    property p_flag_a_clr;
        @(posedge mclk_i) disable iff (rst_i) (clr_a && !rise_a) |=> !cmp_a_edge_flag_r;
    endproperty
    a_flag_a_clr: assert property (p_flag_a_clr) else $error("A flag not cleared");

    property p_clr_reads_zero;
        @(posedge mclk_i) disable iff (rst_i) (rif.addr == ACSF_STATUS_OFS) |-> (rif.rdata[5:4] == 2'b00);
    endproperty
    a_clr_reads_zero: assert property (p_clr_reads_zero) else $error("Clear bits read nonzero");

    property p_zero_keeps;
        @(posedge mclk_i) disable iff (rst_i)
            (wr_status && !rif.wdata[ACSF_A_CLR_BIT] && cmp_a_edge_flag_r) |=> cmp_a_edge_flag_r;
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("Zero write cleared flag");

    property p_offset_gate;
        @(posedge mclk_i) disable iff (rst_i)
            !option_on |-> (!status_img[ACSF_OFFSET_BIT] && !status_img[ACSF_PIN_OE_BIT]);
    endproperty
    a_offset_gate: assert property (p_offset_gate) else $error("Gated bit read nonzero");

    property p_offset_out;
        @(posedge mclk_i) disable iff (rst_i) (!offset_eff || !holds_clear) |=> !sample_offset_o;
    endproperty
    a_offset_out: assert property (p_offset_out) else $error("Offset requested wrongly");

    property p_charge_off;
        @(posedge mclk_i) disable iff (rst_i) !src_en |=> (charge_ctl_o == 3'h0 && !charge_ctl_en_o);
    endproperty
    a_charge_off: assert property (p_charge_off) else $error("Charge active while disabled");

    property p_set_wins;
        @(posedge mclk_i) disable iff (rst_i) (s_rise_b and clr_b) |=> cmp_b_edge_flag_r;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("Clear beat edge");

    property p_irq;
        @(posedge mclk_i) disable iff (rst_i)
            (analog_control_r[ACSF_IRQEN_BIT] && flag_any) |=> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("Interrupt not raised");

    property p_zero_keeps_b;
        @(posedge mclk_i) disable iff (rst_i)
            (wr_status && !rif.wdata[ACSF_B_CLR_BIT] && cmp_b_edge_flag_r) |=> cmp_b_edge_flag_r;
    endproperty
    a_zero_keeps_b: assert property (p_zero_keeps_b) else $error("Zero write cleared B flag");

    property p_set_wins_a;
        @(posedge mclk_i) disable iff (rst_i) (s_rise_a and clr_a) |=> cmp_a_edge_flag_r;
    endproperty
    a_set_wins_a: assert property (p_set_wins_a) else $error("Clear beat A edge");

    property p_hold_b;
        @(posedge mclk_i) disable iff (rst_i) (cmp_b_edge_flag_r && !clr_b) |=> cmp_b_edge_flag_r;
    endproperty
    a_hold_b: assert property (p_hold_b) else $error("B flag lost");

    property p_hold_a;
        @(posedge mclk_i) disable iff (rst_i) (cmp_a_edge_flag_r && !clr_a) |=> cmp_a_edge_flag_r;
    endproperty
    a_hold_a: assert property (p_hold_a) else $error("A flag lost");

    property p_live_read;
        @(posedge mclk_i) disable iff (rst_i)
            (rif.rd && (rif.addr == ACSF_STATUS_OFS)) |-> (rif.rdata[1:0] == {cmp_b_s, cmp_a_s});
    endproperty
    a_live_read: assert property (p_live_read) else $error("Live state bits wrong");

    property p_offset_on;
        @(posedge mclk_i) disable iff (rst_i) (offset_eff && holds_clear) |=> sample_offset_o;
    endproperty
    a_offset_on: assert property (p_offset_on) else $error("Offset not requested");

    property p_pin_follow;
        @(posedge mclk_i) disable iff (rst_i) (pin_oe_eff && config_r[ACSF_DIR_BIT] && cmp_a_s) |=> pin_out_o;
    endproperty
    a_pin_follow: assert property (p_pin_follow) else $error("Pin missed comparator");

    property p_pin_quiet;
        @(posedge mclk_i) disable iff (rst_i)
            (!option_on && !config_r[ACSF_DATA_BIT] && !config_r[ACSF_LEVEL_BIT]) |=> !pin_out_o;
    endproperty
    a_pin_quiet: assert property (p_pin_quiet) else $error("Pin driven without option");

    property p_route_flag;
        @(posedge mclk_i) disable iff (rst_i)
            analog_control_r[ACSF_CAPR_BIT] |=> (capture_src_o == $past(cmp_b_edge_flag_r));
    endproperty
    a_route_flag: assert property (p_route_flag) else $error("Capture not from B flag");

    property p_route_pin;
        @(posedge mclk_i) disable iff (rst_i)
            !analog_control_r[ACSF_CAPR_BIT] |=> (capture_src_o == $past(capture_pin_s));
    endproperty
    a_route_pin: assert property (p_route_pin) else $error("Capture not from pin");

    property p_irq_quiet;
        @(posedge mclk_i) disable iff (rst_i)
            (!(|(irq_stat_r & irq_mask_r)) && !(analog_control_r[ACSF_IRQEN_BIT] && flag_any)) |=> !irq_o;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("Interrupt without cause");

    property p_charge_on;
        @(posedge mclk_i) disable iff (rst_i) src_en |=> charge_ctl_en_o;
    endproperty
    a_charge_on: assert property (p_charge_on) else $error("Source enable not passed");
endmodule
`default_nettype wire

// >>> acsf_top_tb.sv
// Self-checking testbench for the analog status register bank
`timescale 1ns/1ps
`default_nettype none
module acsf_top_tb;
    import acsf_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic hreadyout, hresp, irq, soff, pin, chen, cap_src;
    logic [2:0] chg;
    wire logic cmp_a, cmp_b, cpin;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;

    acsf_cmp_model model (.mclk_i(mclk_i), .cmp_a_o(cmp_a), .cmp_b_o(cmp_b), .capture_pin_o(cpin));

    acsf_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hsize_i(3'h2), .hwrite_i(hwrite), .hready_i(hreadyout), .hwdata_i(hwdata), .hrdata_o(hrdata),
        .hreadyout_o(hreadyout), .hresp_o(hresp), .cmp_a_i(cmp_a), .cmp_b_i(cmp_b), .capture_pin_i(cpin),
        .irq_o(irq), .sample_offset_o(soff), .pin_out_o(pin), .charge_ctl_en_o(chen),
        .charge_ctl_o(chg), .capture_src_o(cap_src));

    // Free-running 200 MHz clock
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end

    // Hang guard, far above the length of the whole sequence
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            $display("Timeout after %0d cycles", cycles);
            test_done();
        end
    end

    task automatic test_done();
        $display("Checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One AHB-Lite single transfer; address held until hready, data until hready again
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
        @(posedge mclk_i);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= ACSF_HTRANS_NONSEQ;
        hwrite <= w;
        @(posedge mclk_i);
        while (hreadyout !== 1'b1) @(posedge mclk_i);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge mclk_i);
        while (hreadyout !== 1'b1) @(posedge mclk_i);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask

    task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000, rd);
        chk(name, exp, rd);
    endtask

    // Registered outputs need a couple of edges after a write lands
    task automatic settle();
        repeat (3) @(posedge mclk_i);
        #1;
    endtask

    // Synchroniser plus flag and irq stages
    task automatic cwait();
        repeat (8) @(posedge mclk_i);
        #1;
    endtask

    task automatic t_reset();
        rdc("status", ACSF_STATUS_OFS, {24'h00_0000, ACSF_STATUS_RST});
        rdc("control", ACSF_CONTROL_OFS, {24'h00_0000, ACSF_CONTROL_RST});
        rdc("irq stat", ACSF_IRQ_STAT_OFS, 32'h0000_0000);
        rdc("irq mask", ACSF_IRQ_MASK_OFS, 32'h0000_0000);
        rdc("config", ACSF_CONFIG_OFS, 32'h0000_0000);
        wr(8'h20, 32'h0000_00FF);
        rdc("unmapped", 8'h20, 32'h0000_0000);
        chk("charge out", 32'h0000_0000, {28'h000_0000, chen, chg});
        chk("irq", 32'h0000_0000, {31'h0, irq});
        chk("hresp", 32'h0000_0000, {31'h0, hresp});
    endtask

    // Edge flag of one comparator: set, held, zero write ignored, one write clears
    task automatic t_flag(input bit is_b, input int fb, input int cb, input int lb);
        wr(ACSF_STATUS_OFS, (32'h1 << ACSF_A_CLR_BIT) | (32'h1 << ACSF_B_CLR_BIT));
        model.drive(is_b, 1'b1);
        cwait();
        rdc("flag and live", ACSF_STATUS_OFS, (32'h1 << fb) | (32'h1 << lb));
        model.drive(is_b, 1'b0);
        cwait();
        rdc("flag held", ACSF_STATUS_OFS, 32'h1 << fb);
        wr(ACSF_STATUS_OFS, 32'h0000_0000);
        rdc("zero write", ACSF_STATUS_OFS, 32'h1 << fb);
        wr(ACSF_STATUS_OFS, 32'h1 << cb);
        rdc("one write", ACSF_STATUS_OFS, 32'h0000_0000);
    endtask

    task automatic t_route();
        wr(ACSF_CONTROL_OFS, 32'h1 << ACSF_CAPR_BIT);
        model.drive(1'b1, 1'b1);
        cwait();
        chk("capture from flag", 32'h1, {31'h0, cap_src});
        model.drive(1'b1, 1'b0);
        wr(ACSF_STATUS_OFS, 32'h1 << ACSF_B_CLR_BIT);
        settle();
        chk("capture flag clear", 32'h0, {31'h0, cap_src});
        wr(ACSF_CONTROL_OFS, 32'h0000_0000);
        model.cap(1'b1);
        cwait();
        chk("capture from pin", 32'h1, {31'h0, cap_src});
        model.cap(1'b0);
        wr(ACSF_IRQ_STAT_OFS, 32'h0000_0003);
    endtask

    task automatic t_irq();
        wr(ACSF_IRQ_MASK_OFS, 32'h1 << ACSF_IRQ_A_BIT);
        model.drive(1'b0, 1'b1);
        cwait();
        chk("irq unmasked", 32'h1, {31'h0, irq});
        rdc("irq stat", ACSF_IRQ_STAT_OFS, 32'h1 << ACSF_IRQ_A_BIT);
        wr(ACSF_IRQ_STAT_OFS, 32'h1 << ACSF_IRQ_A_BIT);
        settle();
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(ACSF_IRQ_MASK_OFS, 32'h0000_0000);
        model.drive(1'b0, 1'b0);
        model.drive(1'b1, 1'b1);
        cwait();
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(ACSF_CONTROL_OFS, 32'h1 << ACSF_IRQEN_BIT);
        settle();
        chk("irq enable", 32'h1, {31'h0, irq});
        wr(ACSF_CONTROL_OFS, 32'h0000_0000);
        model.drive(1'b1, 1'b0);
        wr(ACSF_STATUS_OFS, (32'h1 << ACSF_A_CLR_BIT) | (32'h1 << ACSF_B_CLR_BIT));
        wr(ACSF_IRQ_STAT_OFS, 32'h0000_0003);
    endtask

    // Option-gated offset and pin routing
    task automatic t_option();
        logic [31:0] en;
        en = (32'h1 << ACSF_OFFSET_BIT) | (32'h1 << ACSF_PIN_OE_BIT);
        model.drive(1'b0, 1'b1);
        cwait();
        wr(ACSF_STATUS_OFS, en | (32'h1 << ACSF_A_CLR_BIT));
        wr(ACSF_CONFIG_OFS, 32'h1 << ACSF_DIR_BIT);
        rdc("gated bits", ACSF_STATUS_OFS, 32'h1 << ACSF_A_LIVE_BIT);
        settle();
        chk("offset gated", 32'h0, {31'h0, soff});
        chk("pin gated", 32'h0, {31'h0, pin});
        wr(ACSF_CONFIG_OFS, (32'h1 << ACSF_OPTION_BIT) | (32'h1 << ACSF_DIR_BIT));
        rdc("option bits", ACSF_STATUS_OFS, en | (32'h1 << ACSF_A_LIVE_BIT));
        settle();
        chk("offset on", 32'h1, {31'h0, soff});
        chk("pin comparator", 32'h1, {31'h0, pin});
        wr(ACSF_CONTROL_OFS, 32'h1 << ACSF_HOLD_BIT);
        settle();
        chk("offset hold", 32'h0, {31'h0, soff});
        wr(ACSF_CONTROL_OFS, 32'h1 << ACSF_DIFF_HOLD_BIT);
        settle();
        chk("offset diff hold", 32'h0, {31'h0, soff});
        wr(ACSF_CONFIG_OFS, 32'h1 << ACSF_OPTION_BIT);
        settle();
        chk("pin input dir", 32'h0, {31'h0, pin});
        wr(ACSF_CONFIG_OFS, (32'h1 << ACSF_OPTION_BIT) | (32'h1 << ACSF_DATA_BIT));
        settle();
        chk("pin data", 32'h1, {31'h0, pin});
        wr(ACSF_CONFIG_OFS, (32'h1 << ACSF_OPTION_BIT) | (32'h1 << ACSF_LEVEL_BIT));
        settle();
        chk("pin level", 32'h1, {31'h0, pin});
        model.drive(1'b0, 1'b0);
        wr(ACSF_CONFIG_OFS, 32'h0000_0000);
        wr(ACSF_CONTROL_OFS, 32'h0000_0000);
    endtask

    task automatic t_charge();
        wr(ACSF_CONTROL_OFS, 32'h0000_00E0);
        settle();
        chk("charge off", 32'h0, {28'h000_0000, chen, chg});
        wr(ACSF_CONTROL_OFS, 32'h0000_00E0 | (32'h1 << ACSF_SRC_EN_BIT));
        settle();
        chk("charge on", 32'hF, {28'h000_0000, chen, chg});
        wr(ACSF_CONTROL_OFS, 32'h0000_00E0);
        settle();
        chk("charge cut", 32'h0, {28'h000_0000, chen, chg});
    endtask

    // Edge racing a clear, then a mid-run reset over set flags and controls
    task automatic t_rst_mid();
        logic [31:0] en;
        logic [31:0] race;
        en = (32'h1 << ACSF_OFFSET_BIT) | (32'h1 << ACSF_PIN_OE_BIT);
        race = en | (32'h1 << ACSF_B_FLAG_BIT) | (32'h1 << ACSF_B_LIVE_BIT);
        wr(ACSF_CONFIG_OFS, 32'h1 << ACSF_OPTION_BIT);
        wr(ACSF_CONTROL_OFS, 32'h0000_00F0);
        wr(ACSF_STATUS_OFS, en);
        model.drive(1'b1, 1'b1);
        // Clear commits on the edge where the synchronised rise is taken
        repeat (2) @(posedge mclk_i);
        wr(ACSF_STATUS_OFS, en | (32'h1 << ACSF_B_CLR_BIT));
        rdc("set beats clear", ACSF_STATUS_OFS, race);
        model.drive(1'b1, 1'b0);
        cwait();
        @(posedge mclk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        #1;
        chk("outputs in reset", 32'h0, {24'h00_0000, irq, soff, pin, chen, chg, cap_src});
        @(posedge mclk_i);
        rst_i <= 1'b0;
        rdc("status after reset", ACSF_STATUS_OFS, 32'h0000_0000);
        wr(ACSF_CONFIG_OFS, 32'h1 << ACSF_OPTION_BIT);
        rdc("option bits after reset", ACSF_STATUS_OFS, 32'h0000_0000);
        rdc("control after reset", ACSF_CONTROL_OFS, 32'h0000_0000);
        wr(ACSF_CONFIG_OFS, 32'h0000_0000);
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_reset();
        t_flag(1'b1, ACSF_B_FLAG_BIT, ACSF_B_CLR_BIT, ACSF_B_LIVE_BIT);
        t_flag(1'b0, ACSF_A_FLAG_BIT, ACSF_A_CLR_BIT, ACSF_A_LIVE_BIT);
        t_route();
        t_irq();
        t_option();
        t_charge();
        t_rst_mid();
        test_done();
    end
endmodule
`default_nettype wire
